/* File: core/pcrc_pkg.sv */
// constants, enums and carriers for the programmable crc engine
// assumes a single 40 mhz clock and a word-wide register port
package pcrc_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_SEED = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_SUM = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_DATA = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_STAT = 5'h10;

  typedef enum logic [1:0] {
    POLY_CCITT = 2'b00,
    POLY_CRC16 = 2'b01,
    POLY_CRC32 = 2'b10
  } pcrc_poly_type;

  typedef enum logic [1:0] {
    SIZE_8 = 2'b00,
    SIZE_16 = 2'b01,
    SIZE_32 = 2'b10
  } pcrc_size_type;

  // control register layout, bit 0 upward: poly[1:0], in_rev, in_cmp, out_rev, out_cmp
  typedef struct packed {
    logic out_cmp;
    logic out_rev;
    logic in_cmp;
    logic in_rev;
    pcrc_poly_type poly;
  } pcrc_ctrl_type;

  localparam int CTRL_W = 6;
  localparam pcrc_ctrl_type CTRL_RST = 6'h00;

  localparam logic [31:0] GEN_CCITT = 32'h00001021;
  localparam logic [31:0] GEN_CRC16 = 32'h00008005;
  localparam logic [31:0] GEN_CRC32 = 32'h04c11db7;
  localparam logic [31:0] MASK_16 = 32'h0000ffff;
  localparam logic [31:0] MASK_32 = 32'hffffffff;
  localparam logic [31:0] SEED_RST = 32'h0000ffff;

  // byte steps per write size
  localparam logic [2:0] STEPS_8 = 3'h1;
  localparam logic [2:0] STEPS_16 = 3'h2;
  localparam logic [2:0] STEPS_32 = 3'h4;
  localparam logic [2:0] STEPS_NONE = 3'h0;

  // status bits
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_PEND_BIT = 1;

endpackage

/* File: core/pcrc_byte_step.sv */
// one byte of crc division, msb first, for the selected generator
// assumes crc_in upper half is don't-care in the 16-bit modes
`timescale 1ns/1ps
`default_nettype none
module pcrc_byte_step (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data_in,
  input wire pcrc_pkg::pcrc_poly_type poly,
  output logic [31:0] crc_out
);

  logic [31:0] gen;
  logic wide;

  assign wide = (poly == pcrc_pkg::POLY_CRC32);
  assign gen = (poly == pcrc_pkg::POLY_CRC32) ? pcrc_pkg::GEN_CRC32 : // R4
               (poly == pcrc_pkg::POLY_CRC16) ? pcrc_pkg::GEN_CRC16 : // R3
               pcrc_pkg::GEN_CCITT; // R2

  always_comb begin
    logic [31:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = (wide ? c[31] : c[15]) ^ data_in[i];
      c = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ gen;
      end
    end
    // bits above the generator width never feed back, drop them
    crc_out = wide ? c : (c & pcrc_pkg::MASK_16);
  end

endmodule
`default_nettype wire

/* File: core/pcrc_engine.sv */
// programmable crc engine: register port, byte sequencer, output shaping
// assumes a master that pauses data writes while busy is high
//
// What this block does
// R1: software picks ccitt, crc-16 or crc-32 generator in the control register
// R2: ccitt mode divides by x16+x12+x5+1, 16-bit remainder
// R3: crc-16 mode divides by x16+x15+x2+1, 16-bit remainder
// R4: crc-32 mode divides by the standard 32-bit ethernet generator
// R5: separate bit reversal for input bytes and for the read checksum
// R6: separate ones' complement for input bytes and for the read checksum
// R7: seed write loads the remainder register before data accumulate
// R8: 8, 16, 32-bit data writes in any mix; byte takes one cycle
// R9: 16-bit write is two byte steps, two cycles
// R10: 32-bit write is four byte steps, four cycles
// R11: processor or dma writes back to back with no software between words
// R12: write arriving mid-update is held in a slot and busy stalls the master
// R13: bytes go least significant first; sum read returns shaped remainder
`timescale 1ns/1ps
`default_nettype none
module pcrc_engine (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [pcrc_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire pcrc_pkg::pcrc_size_type wsize,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic busy
);

  function automatic logic [2:0] size_steps(input pcrc_pkg::pcrc_size_type s);
    case (s)
      pcrc_pkg::SIZE_8: size_steps = pcrc_pkg::STEPS_8;
      pcrc_pkg::SIZE_16: size_steps = pcrc_pkg::STEPS_16;
      default: size_steps = pcrc_pkg::STEPS_32;
    endcase
  endfunction

  function automatic logic [31:0] width_mask(input pcrc_pkg::pcrc_poly_type p);
    width_mask = (p == pcrc_pkg::POLY_CRC32) ? pcrc_pkg::MASK_32 : pcrc_pkg::MASK_16;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = b[7-i];
    end
  endfunction

  // reversal spans the generator width, complement too
  function automatic logic [31:0] shape_sum(input logic [31:0] c,
                                            input pcrc_pkg::pcrc_ctrl_type k);
    logic [31:0] m;
    logic [31:0] r;
    m = width_mask(k.poly);
    r = c & m;
    if (k.out_rev) begin
      r = {<<{r}};
      if (k.poly != pcrc_pkg::POLY_CRC32) begin
        r = r >> 16;
      end
    end
    if (k.out_cmp) begin
      r = r ^ m;
    end
    shape_sum = r;
  endfunction

  function automatic pcrc_pkg::pcrc_ctrl_type pcrc_ctrl_cast(input logic [5:0] v);
    pcrc_ctrl_cast = v;
  endfunction

  pcrc_pkg::pcrc_ctrl_type ctrl_r;
  logic [31:0] seed_r;
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic [2:0] left_r;
  logic [2:0] left_nxt;
  logic [31:0] pend_data_r;
  logic [2:0] pend_len_r;
  logic pend_v_r;
  logic pend_v_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic busy_r;

  wire wr_ctrl = wr && (addr == pcrc_pkg::OFF_CTRL);
  wire wr_seed = wr && (addr == pcrc_pkg::OFF_SEED);
  wire wr_data = wr && (addr == pcrc_pkg::OFF_DATA);
  wire step_en = (left_r != pcrc_pkg::STEPS_NONE);
  // the engine is idle or finishes its last byte this cycle, so it can load again
  wire done_now = (left_r <= pcrc_pkg::STEPS_8);
  wire take_pend = done_now && pend_v_r;
  wire take_bus = wr_data && done_now && !pend_v_r;
  wire to_pend = wr_data && (take_pend || (!done_now && !pend_v_r));
  wire [2:0] bus_steps = size_steps(wsize);

  wire [7:0] byte_raw = shift_r[7:0];
  wire [7:0] byte_ord = ctrl_r.in_rev ? rev8(byte_raw) : byte_raw; // R5
  wire [7:0] byte_in = ctrl_r.in_cmp ? ~byte_ord : byte_ord; // R6
  wire [31:0] crc_step;
  wire [31:0] sum_val = shape_sum(crc_r, ctrl_r); // R13

  pcrc_byte_step u_step (
    .crc_in(crc_r),
    .data_in(byte_in),
    .poly(ctrl_r.poly),
    .crc_out(crc_step)
  );

  // seed wins over any step and cancels work in flight
  assign crc_nxt = wr_seed ? wdata : (step_en ? crc_step : crc_r); // R7
  assign shift_nxt = take_pend ? pend_data_r :
                     take_bus ? wdata :
                     step_en ? {8'h00, shift_r[31:8]} : shift_r; // R13
  assign left_nxt = wr_seed ? pcrc_pkg::STEPS_NONE :
                    take_pend ? pend_len_r :
                    take_bus ? bus_steps :
                    step_en ? left_r - 3'h1 : left_r; // R8 R9 R10
  assign pend_v_nxt = wr_seed ? 1'b0 :
                      to_pend ? 1'b1 :
                      take_pend ? 1'b0 : pend_v_r; // R12

  wire [31:0] stat_val = {30'h0, pend_v_r, step_en};
  wire [31:0] rd_val = (addr == pcrc_pkg::OFF_CTRL) ? {26'h0, ctrl_r} :
                       (addr == pcrc_pkg::OFF_SEED) ? seed_r :
                       (addr == pcrc_pkg::OFF_SUM) ? sum_val :
                       (addr == pcrc_pkg::OFF_STAT) ? stat_val : 32'h0;
  assign rdata_nxt = rd ? rd_val : 32'h0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= pcrc_pkg::CTRL_RST;
      seed_r <= pcrc_pkg::SEED_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pcrc_ctrl_cast(wdata[pcrc_pkg::CTRL_W-1:0]); // R1
      end
      if (wr_seed) begin
        seed_r <= wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crc_r <= pcrc_pkg::SEED_RST;
      shift_r <= 32'h0;
      left_r <= pcrc_pkg::STEPS_NONE;
    end else begin
      crc_r <= crc_nxt;
      shift_r <= shift_nxt;
      left_r <= left_nxt;
    end
  end

  // one holding slot lets dma run back to back without losing a word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_data_r <= 32'h0;
      pend_len_r <= pcrc_pkg::STEPS_NONE;
      pend_v_r <= 1'b0;
    end else begin
      if (to_pend) begin
        pend_data_r <= wdata; // R11
        pend_len_r <= bus_steps;
      end
      pend_v_r <= pend_v_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0;
      busy_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      busy_r <= pend_v_nxt; // R12
    end
  end

  assign rdata = rdata_r;
  assign busy = busy_r;

  // checks

  wire idle_now = (left_r == pcrc_pkg::STEPS_NONE) && !pend_v_r;

  property p_byte_one;
    @(posedge sys_clk) disable iff (rst)
    (wr_data && idle_now && wsize == pcrc_pkg::SIZE_8) ##1 !wr_data |->
      (left_r == 3'h1) ##1 (left_r == 3'h0);
  endproperty
  a_byte_one: assert property (p_byte_one) else $error("byte write not one step"); // R8

  property p_half_two;
    @(posedge sys_clk) disable iff (rst)
    (wr_data && idle_now && wsize == pcrc_pkg::SIZE_16) ##1 !wr_seed |=>
      (left_r == 3'h1) && ($past(left_r) == 3'h2);
  endproperty
  a_half_two: assert property (p_half_two) else $error("half write not two steps"); // R9

  property p_word_four;
    @(posedge sys_clk) disable iff (rst)
    (wr_data && idle_now && wsize == pcrc_pkg::SIZE_32) ##1 !wr_seed[*3] |=>
      (left_r == 3'h1) && ($past(left_r, 3) == 3'h4);
  endproperty
  a_word_four: assert property (p_word_four) else $error("word write not four steps"); // R10

  property p_seed_load;
    @(posedge sys_clk) disable iff (rst)
    wr_seed |=> (crc_r == $past(wdata)) && (left_r == 3'h0) && !busy_r;
  endproperty
  a_seed_load: assert property (p_seed_load) else $error("seed not loaded"); // R7

  property p_hold_off;
    @(posedge sys_clk) disable iff (rst)
    (wr_data && !done_now && !pend_v_r && !wr_seed) |=>
      busy_r && (pend_data_r == $past(wdata));
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("mid-update write lost"); // R12

  property p_lsb_first;
    @(posedge sys_clk) disable iff (rst)
    (wr_data && idle_now && wsize == pcrc_pkg::SIZE_16) |=>
      (shift_r[7:0] == $past(wdata[7:0])) ##1
      (shift_r[7:0] == $past(wdata[15:8], 2));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("byte order wrong"); // R13

  property p_gen_ccitt;
    @(posedge sys_clk) disable iff (rst)
    (step_en && !wr_seed && crc_r == 32'h0 && byte_in == 8'h01 &&
     ctrl_r.poly == pcrc_pkg::POLY_CCITT) |=> (crc_r == 32'h00001021);
  endproperty
  a_gen_ccitt: assert property (p_gen_ccitt) else $error("ccitt generator wrong"); // R2

  property p_gen_crc16;
    @(posedge sys_clk) disable iff (rst)
    (step_en && !wr_seed && crc_r == 32'h0 && byte_in == 8'h01 &&
     ctrl_r.poly == pcrc_pkg::POLY_CRC16) |=> (crc_r == 32'h00008005);
  endproperty
  a_gen_crc16: assert property (p_gen_crc16) else $error("crc16 generator wrong"); // R3

  property p_gen_crc32;
    @(posedge sys_clk) disable iff (rst)
    (step_en && !wr_seed && crc_r == 32'h0 && byte_in == 8'h01 &&
     ctrl_r.poly == pcrc_pkg::POLY_CRC32) |=> (crc_r == 32'h04c11db7);
  endproperty
  a_gen_crc32: assert property (p_gen_crc32) else $error("crc32 generator wrong"); // R4

  property p_narrow;
    @(posedge sys_clk) disable iff (rst)
    (step_en && !wr_seed && ctrl_r.poly != pcrc_pkg::POLY_CRC32 && !wr_ctrl) |=>
      (crc_r[31:16] == 16'h0);
  endproperty
  a_narrow: assert property (p_narrow) else $error("16-bit mode leaks high bits"); // R1

  property p_in_cmp;
    @(posedge sys_clk) disable iff (rst)
    (ctrl_r.in_cmp && !ctrl_r.in_rev) |-> (byte_in == ~shift_r[7:0]);
  endproperty
  a_in_cmp: assert property (p_in_cmp) else $error("input complement wrong"); // R6

  property p_sum_read;
    @(posedge sys_clk) disable iff (rst)
    (rd && addr == pcrc_pkg::OFF_SUM && ctrl_r.out_cmp && !ctrl_r.out_rev) |=>
      (rdata_r == (($past(crc_r) ^ 32'hffffffff) & width_mask($past(ctrl_r.poly))));
  endproperty
  a_sum_read: assert property (p_sum_read) else $error("sum read not shaped"); // R13

  property p_out_rev;
    @(posedge sys_clk) disable iff (rst)
    (rd && addr == pcrc_pkg::OFF_SUM && ctrl_r.out_rev && !ctrl_r.out_cmp &&
     ctrl_r.poly == pcrc_pkg::POLY_CRC32) |=> (rdata_r == {<<{$past(crc_r)}});
  endproperty
  a_out_rev: assert property (p_out_rev) else $error("output reversal wrong"); // R5

  property p_chain;
    @(posedge sys_clk) disable iff (rst)
    (take_pend && !wr_seed) |=> (left_r == $past(pend_len_r));
  endproperty
  a_chain: assert property (p_chain) else $error("held write not started"); // R11

  c_byte: cover property (@(posedge sys_clk) disable iff (rst)
    wr_data && wsize == pcrc_pkg::SIZE_8);
  c_back_to_back: cover property (@(posedge sys_clk) disable iff (rst)
    wr_data && wsize == pcrc_pkg::SIZE_32 ##1 wr_data ##1 busy_r);
  c_chain: cover property (@(posedge sys_clk) disable iff (rst) take_pend);
  c_sum: cover property (@(posedge sys_clk) disable iff (rst)
    rd && addr == pcrc_pkg::OFF_SUM && ctrl_r.out_rev && ctrl_r.out_cmp);

endmodule
`default_nettype wire

/* File: test/pcrc_dma_model.sv */
// stand-in for a dma channel pushing 32-bit words into the data register
// assumes the engine raises busy one cycle after a write that fills its slot
`timescale 1ns/1ps
`default_nettype none
module pcrc_dma_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] count,
  input wire logic [31:0] base,
  input wire logic busy,
  output logic [pcrc_pkg::ADDR_W-1:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic done
);
  logic [3:0] left_r;
  logic [3:0] idx_r;
  assign addr = pcrc_pkg::OFF_DATA;
  assign done = (left_r == 4'h0) && !wr;
  // a gap after each write: busy for that write is only seen one cycle later
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      left_r <= 4'h0;
      idx_r <= 4'h0;
      wr <= 1'b0;
      wdata <= 32'h0;
    end else begin
      wdata <= ~wdata;
      wr <= 1'b0;
      if (start) begin
        left_r <= count;
        idx_r <= 4'h0;
      end else if (!wr && left_r != 4'h0 && !busy) begin
        wr <= 1'b1;
        wdata <= base + 32'(idx_r) * 32'h01010101;
        idx_r <= idx_r + 4'h1;
        left_r <= left_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/pcrc_engine_test.sv */
// self-checking bench for the crc engine with a reference remainder model
// assumes the engine and the dma model share one 40 mhz clock
`timescale 1ns/1ps
`default_nettype none
module pcrc_engine_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] t_addr = 5'h00;
  logic [31:0] t_wdata = 32'h0;
  pcrc_pkg::pcrc_size_type t_wsize = pcrc_pkg::SIZE_8;
  logic t_wr = 1'b0;
  logic rd = 1'b0;
  logic dma_on = 1'b0;
  logic m_start = 1'b0;
  logic [3:0] m_count = 4'h6;
  logic [31:0] m_base = 32'h1f2e3d4c;
  logic [4:0] m_addr;
  logic [31:0] m_wdata;
  logic m_wr;
  logic m_done;
  logic [31:0] rdata;
  logic busy;
  int err_count = 0;
  int n_tests = 0;
  logic [5:0] ctl = 6'h00;
  logic [31:0] crc = 32'h0000ffff;
  wire logic [4:0] addr = dma_on ? m_addr : t_addr;
  wire logic [31:0] wdata = dma_on ? m_wdata : t_wdata;
  wire logic wr = dma_on ? m_wr : t_wr;
  pcrc_pkg::pcrc_size_type wsize;
  assign wsize = dma_on ? pcrc_pkg::SIZE_32 : t_wsize;

  always #12.5 sys_clk = ~sys_clk;

  pcrc_engine DUT (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wsize(wsize), .wr(wr), .rd(rd), .rdata(rdata), .busy(busy));
  pcrc_dma_model dma (.sys_clk(sys_clk), .rst(rst), .start(m_start), .count(m_count),
    .base(m_base), .busy(busy), .addr(m_addr), .wdata(m_wdata), .wr(m_wr), .done(m_done));

  function automatic logic [31:0] msk();
    return ctl[1:0] == 2'b10 ? pcrc_pkg::MASK_32 : pcrc_pkg::MASK_16;
  endfunction
  function automatic logic [31:0] brev(input logic [31:0] v, input int n);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < n; i++) r[i] = v[n-1-i];
    return r;
  endfunction
  function automatic logic [31:0] shaped();
    logic [31:0] s;
    s = crc & msk();
    if (ctl[4]) s = brev(s, ctl[1:0] == 2'b10 ? 32 : 16);
    if (ctl[5]) s = s ^ msk();
    return s;
  endfunction
  task automatic feed(input logic [31:0] d, input int n);
    logic [7:0] b;
    logic [31:0] g;
    int top;
    g = ctl[1:0] == 2'b01 ? pcrc_pkg::GEN_CRC16 :
        ctl[1:0] == 2'b10 ? pcrc_pkg::GEN_CRC32 : pcrc_pkg::GEN_CCITT;
    top = ctl[1:0] == 2'b10 ? 31 : 15;
    for (int k = 0; k < n; k++) begin
      b = d[8*k +: 8];
      if (ctl[2]) b = brev({24'h0, b}, 8);
      if (ctl[3]) b = ~b;
      for (int i = 7; i >= 0; i--) crc = (b[i] ^ crc[top]) ? (crc << 1) ^ g : crc << 1;
      crc = crc & msk();
    end
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d,
                        input pcrc_pkg::pcrc_size_type s);
    @(posedge sys_clk);
    t_addr <= a;
    t_wdata <= d;
    t_wsize <= s;
    t_wr <= 1'b1;
    @(posedge sys_clk);
    t_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] want, input string what);
    @(posedge sys_clk);
    t_addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    check(rdata, want, what);
  endtask
  task automatic dw(input logic [31:0] d, input pcrc_pkg::pcrc_size_type s, input int n);
    wr_reg(pcrc_pkg::OFF_DATA, d, s);
    feed(d, n);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic set_mode(input logic [5:0] c, input logic [31:0] seed);
    ctl = c;
    wr_reg(pcrc_pkg::OFF_CTRL, {26'h0, c}, pcrc_pkg::SIZE_32);
    wr_reg(pcrc_pkg::OFF_SEED, seed, pcrc_pkg::SIZE_32);
    crc = seed & msk();
    rd_chk(pcrc_pkg::OFF_CTRL, {26'h0, c}, "ctrl readback");
    rd_chk(pcrc_pkg::OFF_SUM, shaped(), "seeded sum");
  endtask

  task automatic t_reset();
    rd_chk(pcrc_pkg::OFF_CTRL, 32'h0, "ctrl reset");
    rd_chk(pcrc_pkg::OFF_SEED, pcrc_pkg::SEED_RST, "seed reset");
    rd_chk(pcrc_pkg::OFF_SUM, 32'h0000ffff, "sum reset");
    rd_chk(pcrc_pkg::OFF_DATA, 32'h0, "data reads zero");
    rd_chk(5'h14, 32'h0, "unmapped read");
    $display("reset test done");
  endtask
  task automatic t_known();
    logic [5:0] kc [3] = '{6'h00, 6'h15, 6'h36};
    logic [31:0] ks [3] = '{32'h0000ffff, 32'h0, 32'hffffffff};
    logic [31:0] kw [3] = '{32'h29b1, 32'hbb3d, 32'hcbf43926};
    for (int i = 0; i < 3; i++) begin
      set_mode(kc[i], ks[i]);
      dw(32'h34333231, pcrc_pkg::SIZE_32, 4);
      dw(32'h5a5a3635, pcrc_pkg::SIZE_16, 2);
      dw(32'hc3c3c337, pcrc_pkg::SIZE_8, 1);
      dw(32'h00003938, pcrc_pkg::SIZE_16, 2);
      rd_chk(pcrc_pkg::OFF_SUM, kw[i], "check value");
    end
    $display("known value test done");
  endtask
  task automatic t_gen();
    logic [5:0] gc [3] = '{6'h00, 6'h01, 6'h02};
    logic [31:0] gw [3] = '{32'h00001021, 32'h00008005, 32'h04c11db7};
    for (int i = 0; i < 3; i++) begin
      set_mode(gc[i], 32'h0);
      dw(32'h00000001, pcrc_pkg::SIZE_8, 1);
      rd_chk(pcrc_pkg::OFF_SUM, gw[i], "single bit remainder");
    end
    $display("generator test done");
  endtask
  task automatic t_shape();
    logic [5:0] sc [6] = '{6'h0c, 6'h31, 6'h3e, 6'h1d, 6'h2a, 6'h12};
    for (int i = 0; i < 6; i++) begin
      set_mode(sc[i], 32'h1234abcd);
      dw(32'h89abcdef, pcrc_pkg::SIZE_32, 4);
      dw(32'h0000a55a, pcrc_pkg::SIZE_16, 2);
      rd_chk(pcrc_pkg::OFF_SUM, shaped(), "shaped sum");
    end
    $display("shaping test done");
  endtask
  task automatic t_timing(input pcrc_pkg::pcrc_size_type s, input int n);
    @(posedge sys_clk);
    t_addr <= pcrc_pkg::OFF_DATA;
    t_wdata <= 32'h0f1e2d3c;
    t_wsize <= s;
    t_wr <= 1'b1;
    @(posedge sys_clk);
    t_wr <= 1'b0;
    t_addr <= pcrc_pkg::OFF_STAT;
    rd <= 1'b1;
    for (int i = 1; i <= n + 1; i++) begin
      @(posedge sys_clk);
      if (i > n) rd <= 1'b0;
      #1;
      check(rdata, {31'h0, i <= n}, "stepping flag");
    end
    feed(32'h0f1e2d3c, n);
    rd_chk(pcrc_pkg::OFF_SUM, shaped(), "timed sum");
    $display("timing test done");
  endtask
  task automatic t_refuse();
    @(posedge sys_clk);
    t_addr <= pcrc_pkg::OFF_DATA;
    t_wsize <= pcrc_pkg::SIZE_32;
    t_wdata <= 32'h11223344;
    t_wr <= 1'b1;
    @(posedge sys_clk);
    t_wdata <= 32'h55667788;
    @(posedge sys_clk);
    t_wdata <= 32'h99aabbcc;
    #1;
    check({31'h0, busy}, 32'h1, "busy with slot full");
    @(posedge sys_clk);
    t_wr <= 1'b0;
    feed(32'h11223344, 4);
    feed(32'h55667788, 4);
    repeat (10) @(posedge sys_clk);
    rd_chk(pcrc_pkg::OFF_SUM, shaped(), "held write kept");
    rd_chk(pcrc_pkg::OFF_STAT, 32'h0, "idle status");
    $display("hold-off test done");
  endtask
  task automatic t_dma();
    @(posedge sys_clk);
    dma_on <= 1'b1;
    m_start <= 1'b1;
    @(posedge sys_clk);
    m_start <= 1'b0;
    for (int k = 0; k < 200; k++) begin
      @(posedge sys_clk);
      #1;
      if (m_done === 1'b1) break;
    end
    check({31'h0, m_done}, 32'h1, "dma finished");
    repeat (6) @(posedge sys_clk);
    dma_on <= 1'b0;
    for (int i = 0; i < 6; i++) feed(m_base + i * 32'h01010101, 4);
    rd_chk(pcrc_pkg::OFF_SUM, shaped(), "dma sum");
    $display("dma test done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_known();
    t_gen();
    t_shape();
    t_timing(pcrc_pkg::SIZE_8, 1);
    t_timing(pcrc_pkg::SIZE_16, 2);
    t_timing(pcrc_pkg::SIZE_32, 4);
    t_refuse();
    t_dma();
    report_and_stop();
  end
endmodule
`default_nettype wire
